// File: cmtg_pkg.sv
// shared constants and types for the clock mode and tick generator
package cmtg_pkg;

  // strap widths
  localparam int unsigned CMTG_HI_W = 4;
  localparam int unsigned CMTG_LO_W = 3;
  localparam int unsigned CMTG_MODE_W = CMTG_HI_W + CMTG_LO_W;

  // decoded ratios: factors with halves are held doubled
  typedef struct packed {
    logic valid;
    logic [3:0] cpm_mult;
    logic [4:0] core_x2;
    logic [3:0] div_x2;
  } cmtg_ratio_s;

  // the four memory-controller tick points
  typedef struct packed {
    logic first;
    logic second;
    logic third;
    logic fourth;
  } cmtg_tick_s;

  typedef enum logic [1:0] {
    CMTG_SP_QUARTER,
    CMTG_SP_TENTHS,
    CMTG_SP_FOURTEENTHS
  } cmtg_spacing_e;

  // one input-clock cycle in ref_clk steps; 140 is lcm of 4, 10, 14
  localparam int unsigned CMTG_PH_N = 140;
  localparam logic [7:0] CMTG_PH_LAST = 8'(CMTG_PH_N - 1);
  localparam logic [7:0] CMTG_T1_POS = 8'h00;
  localparam logic [7:0] CMTG_T3_POS = 8'(CMTG_PH_N / 2);
  localparam logic [7:0] CMTG_T2_QTR = 8'(CMTG_PH_N * 1 / 4);
  localparam logic [7:0] CMTG_T4_QTR = 8'(CMTG_PH_N * 3 / 4);
  localparam logic [7:0] CMTG_T2_TEN = 8'(CMTG_PH_N * 3 / 10);
  localparam logic [7:0] CMTG_T4_TEN = 8'(CMTG_PH_N * 8 / 10);
  localparam logic [7:0] CMTG_T2_FRT = 8'(CMTG_PH_N * 4 / 14);
  localparam logic [7:0] CMTG_T4_FRT = 8'(CMTG_PH_N * 11 / 14);

  // core ratios with non-quarter spacing, doubled
  localparam logic [4:0] CMTG_CORE_X2_2P5 = 5'h05;
  localparam logic [4:0] CMTG_CORE_X2_3P5 = 5'h07;

  // register byte offsets
  localparam logic [7:0] CMTG_OFS_CTRL = 8'h00;
  localparam logic [7:0] CMTG_OFS_FREQ = 8'h04;
  localparam logic [7:0] CMTG_OFS_STAT = 8'h08;
  localparam logic [7:0] CMTG_OFS_CPMF = 8'h0c;
  localparam logic [7:0] CMTG_OFS_BUSF = 8'h10;
  localparam logic [7:0] CMTG_OFS_CORF = 8'h14;

  // field positions
  localparam int unsigned CMTG_CTRL_TICK_EN = 0;
  localparam int unsigned CMTG_STAT_MODE_LSB = 0;
  localparam int unsigned CMTG_STAT_HALVE = 7;
  localparam int unsigned CMTG_STAT_VALID = 8;
  localparam int unsigned CMTG_STAT_CPM_LSB = 12;
  localparam int unsigned CMTG_STAT_CORE_LSB = 16;
  localparam int unsigned CMTG_STAT_DIV_LSB = 24;

  // reset values
  localparam logic [31:0] CMTG_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CMTG_FREQ_RST = 32'h0001_01d0;

  // ahb-lite codes
  localparam logic [1:0] CMTG_HTRANS_NONSEQ = 2'h2;
  localparam logic CMTG_HRESP_OKAY = 1'h0;

endpackage

// File: cmtg_mode_decode.sv
// strap mode code to clock ratio lookup
`timescale 1ns/1ns
`default_nettype none
module cmtg_mode_decode
  import cmtg_pkg::*;
(
  // strap code
  input wire logic [CMTG_HI_W-1:0] hi,
  input wire logic [CMTG_LO_W-1:0] lo,
  // decoded ratios
  output cmtg_ratio_s ratio
);

  always_comb begin
    ratio = '0;
    case (hi)
      4'h0: begin
        case (lo)
          3'h4: ratio = '{1'b1, 4'h3, 5'h06, 4'h5};
          3'h5: ratio = '{1'b1, 4'h3, 5'h07, 4'h5};
          3'h6: ratio = '{1'b1, 4'h4, 5'h07, 4'h6};
          3'h7: ratio = '{1'b1, 4'h4, 5'h06, 4'h5};
          default: ratio = '0;
        endcase
      end
      4'h1: begin
        if (lo >= 3'h1 && lo <= 3'h4) begin
          ratio = '{1'b1, 4'h2, 5'(({2'h0, lo} + 5'h4) << 1), 4'h8};
        end
      end
      4'h2: begin
        if (lo >= 3'h1 && lo <= 3'h4) begin
          ratio = '{1'b1, 4'h3, 5'({2'h0, lo} + 5'h5), 4'h5};
        end
      end
      4'h3: begin
        if (lo <= 3'h4) begin
          ratio = '{1'b1, 4'h2, 5'({2'h0, lo} + 5'h5), 4'h6};
        end
      end
      4'h4: begin
        if (lo <= 3'h2) begin
          ratio = '{1'b1, 4'h3, 5'({2'h0, lo} + 5'h5), 4'h6};
        end
      end
      default: ratio = '0;
    endcase
  end

endmodule // cmtg_mode_decode
`default_nettype wire

// File: cmtg_tick_gen.sv
// four-tick phase generator over one input-clock cycle
`timescale 1ns/1ns
`default_nettype none
module cmtg_tick_gen
  import cmtg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // control
  input wire logic enable,
  input wire cmtg_spacing_e spacing,
  // ticks
  output cmtg_tick_s tick,
  output logic in_clk_level
);

  logic [7:0] phase_ff;
  logic [7:0] nxt_phase;
  logic [7:0] t2_pos;
  logic [7:0] t4_pos;
  cmtg_tick_s tick_ff;
  cmtg_tick_s nxt_tick;
  logic level_ff;
  logic nxt_level;

  always_comb begin
    case (spacing)
      CMTG_SP_TENTHS: begin
        t2_pos = CMTG_T2_TEN;
        t4_pos = CMTG_T4_TEN;
      end
      CMTG_SP_FOURTEENTHS: begin
        t2_pos = CMTG_T2_FRT;
        t4_pos = CMTG_T4_FRT;
      end
      default: begin
        t2_pos = CMTG_T2_QTR;
        t4_pos = CMTG_T4_QTR;
      end
    endcase
    nxt_phase = (phase_ff == CMTG_PH_LAST) ? 8'h00 : phase_ff + 8'h01;
    nxt_tick.first = enable && (phase_ff == CMTG_T1_POS);
    nxt_tick.second = enable && (phase_ff == t2_pos);
    nxt_tick.third = enable && (phase_ff == CMTG_T3_POS);
    nxt_tick.fourth = enable && (phase_ff == t4_pos);
    nxt_level = phase_ff < CMTG_T3_POS;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      phase_ff <= 8'h00;
      tick_ff <= '0;
      level_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tick_ff <= nxt_tick;
      level_ff <= nxt_level;
    end
  end

  assign tick = tick_ff;
  assign in_clk_level = level_ff;

endmodule // cmtg_tick_gen
`default_nettype wire

// File: cmtg_top.sv
// clock mode strap decode, frequency derivation and tick generation
//
// Summary of operation
// - high field 0000 gives agent default ratios
// - 0001 codes: cpm 2/4, div 4
// - 0010 codes: cpm 3/6, div 2.5
// - 0011 codes: cpm 2/4, div 3
// - 0100 codes: cpm 3/6, div 3
// - halving select doubles cpm multiplier
// - core freq is bus freq times core
// - bus freq is cpm freq over div
// - four ticks in each input cycle
// - first on rise, third on fall
// - integer ratios: quarter and three quarters
// - ratio 2.5: three and eight tenths
// - ratio 3.5: four, eleven fourteenths
// - other outputs launched on rising edge
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module cmtg_top
  import cmtg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // reset configuration straps
  input wire logic [CMTG_HI_W-1:0] mode_strap_high_field,
  input wire logic [CMTG_LO_W-1:0] mode_strap_low_field,
  input wire logic pci_clock_halving_select,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // decoded configuration
  output cmtg_ratio_s ratio_out,
  output logic cpm_mult_doubled,
  output logic mode_reserved,
  // memory-controller ticks
  output cmtg_tick_s tick_out,
  output logic bus_input_clock
);

  // strap synchronisers
  logic [CMTG_MODE_W:0] strap_meta_ff;
  logic [CMTG_MODE_W:0] nxt_strap_meta;
  logic [CMTG_MODE_W:0] strap_sync_ff;
  logic [CMTG_MODE_W:0] nxt_strap_sync;

  // captured configuration
  logic captured_ff;
  logic nxt_captured;
  logic [CMTG_MODE_W-1:0] mode_ff;
  logic [CMTG_MODE_W-1:0] nxt_mode;
  logic halve_ff;
  logic nxt_halve;
  cmtg_ratio_s dec_ratio;
  cmtg_ratio_s ratio_ff;
  cmtg_ratio_s nxt_ratio;
  cmtg_spacing_e spacing_ff;
  cmtg_spacing_e nxt_spacing;
  // reserved flag and synchroniser fill
  logic reserved_ff;
  logic nxt_reserved;
  logic [1:0] fill_ff;
  logic [1:0] nxt_fill;
  logic strap_ok_ff;
  logic nxt_strap_ok;

  // bus state
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] freq_ff;
  logic [31:0] nxt_freq;
  logic accept;
  logic [7:0] acc_addr;
  logic [31:0] stat_word;
  logic addr_hi_ok;
  logic tick_en;

  // derived frequencies
  // core and divider factors are held doubled so that halves stay exact
  logic [31:0] cpmf_ff;
  logic [31:0] nxt_cpmf;
  logic [31:0] busf_ff;
  logic [31:0] nxt_busf;
  logic [31:0] corf_ff;
  logic [31:0] nxt_corf;
  logic [4:0] cpm_eff;
  logic [36:0] cpm_prod;
  logic [37:0] bus_num;
  logic [37:0] bus_quot;
  logic [42:0] core_prod;

  // straps come from pins, so two flops before use
  always_comb begin
    nxt_strap_meta = {pci_clock_halving_select,
                      mode_strap_high_field,
                      mode_strap_low_field};
    nxt_strap_sync = strap_meta_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      strap_meta_ff <= '0;
      strap_sync_ff <= '0;
    end else begin
      strap_meta_ff <= nxt_strap_meta;
      strap_sync_ff <= nxt_strap_sync;
    end
  end

  cmtg_mode_decode cmtg_mode_decode_i (
    .hi (mode_ff[CMTG_MODE_W-1:CMTG_LO_W]),
    .lo (mode_ff[CMTG_LO_W-1:0]),
    .ratio (dec_ratio)
  );

  always_comb begin
    nxt_captured = captured_ff;
    nxt_mode = mode_ff;
    nxt_halve = halve_ff;
    if (!captured_ff && strap_ok_ff) begin
      nxt_captured = 1'b1;
      nxt_mode = strap_sync_ff[CMTG_MODE_W-1:0];
      nxt_halve = strap_sync_ff[CMTG_MODE_W];
    end
    nxt_ratio = dec_ratio;
    // reserved flag lines up with the ratios
    nxt_reserved = captured_ff && !dec_ratio.valid;
    if (dec_ratio.core_x2 == CMTG_CORE_X2_2P5) begin
      nxt_spacing = CMTG_SP_TENTHS;
    end else if (dec_ratio.core_x2 == CMTG_CORE_X2_3P5) begin
      nxt_spacing = CMTG_SP_FOURTEENTHS;
    end else begin
      nxt_spacing = CMTG_SP_QUARTER;
    end
  end

  // synchroniser needs two edges to fill before capture
  always_comb begin
    nxt_fill = (fill_ff == 2'h3) ? fill_ff : fill_ff + 2'h1;
    nxt_strap_ok = (fill_ff == 2'h3);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fill_ff <= 2'h0;
      strap_ok_ff <= 1'b0;
      captured_ff <= 1'b0;
      mode_ff <= '0;
      halve_ff <= 1'b0;
      ratio_ff <= '0;
      spacing_ff <= CMTG_SP_QUARTER;
      reserved_ff <= 1'b0;
    end else begin
      fill_ff <= nxt_fill;
      strap_ok_ff <= nxt_strap_ok;
      captured_ff <= nxt_captured;
      mode_ff <= nxt_mode;
      halve_ff <= nxt_halve;
      ratio_ff <= nxt_ratio;
      spacing_ff <= nxt_spacing;
      reserved_ff <= nxt_reserved;
    end
  end

  // frequencies in khz; pipelined one register deep
  always_comb begin
    cpm_eff = halve_ff ? {ratio_ff.cpm_mult, 1'b0}
                       : {1'b0, ratio_ff.cpm_mult};
    cpm_prod = 37'(freq_ff) * 37'(cpm_eff);
    bus_num = {cpm_prod, 1'b0};
    // bus from cpm and divider
    // reserved codes leave the divider zero, hence the guard
    bus_quot = ratio_ff.valid ? bus_num / 38'(ratio_ff.div_x2) : '0;
    // core from bus and core factor
    core_prod = 43'(bus_quot) * 43'(ratio_ff.core_x2);
    if (ratio_ff.valid) begin
      nxt_cpmf = cpm_prod[31:0];
      nxt_busf = bus_quot[31:0];
      nxt_corf = core_prod[32:1];
    end else begin
      nxt_cpmf = 32'h0;
      nxt_busf = 32'h0;
      nxt_corf = 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cpmf_ff <= 32'h0;
      busf_ff <= 32'h0;
      corf_ff <= 32'h0;
    end else begin
      cpmf_ff <= nxt_cpmf;
      busf_ff <= nxt_busf;
      corf_ff <= nxt_corf;
    end
  end

  // status word is a plain view of the captured state
  always_comb begin
    stat_word = 32'h0;
    stat_word[CMTG_STAT_MODE_LSB +: CMTG_MODE_W] = mode_ff;
    stat_word[CMTG_STAT_HALVE] = halve_ff;
    stat_word[CMTG_STAT_VALID] = ratio_ff.valid;
    stat_word[CMTG_STAT_CPM_LSB +: 4] = ratio_ff.cpm_mult;
    stat_word[CMTG_STAT_CORE_LSB +: 5] = ratio_ff.core_x2;
    stat_word[CMTG_STAT_DIV_LSB +: 4] = ratio_ff.div_x2;
  end

  // bus slave: zero wait, reads answered from a flop
  always_comb begin
    accept = hsel && hready && (htrans == CMTG_HTRANS_NONSEQ);
    acc_addr = haddr[7:0];
    // only the low page is mapped; writes above it are dropped
    addr_hi_ok = haddr[31:8] == 24'h0;
    nxt_wr_pend = accept && hwrite && addr_hi_ok;
    nxt_wr_addr = accept ? acc_addr : wr_addr_ff;
    nxt_ctrl = ctrl_ff;
    nxt_freq = freq_ff;
    if (wr_pend_ff && wr_addr_ff == CMTG_OFS_CTRL) begin
      nxt_ctrl = {31'h0, hwdata[CMTG_CTRL_TICK_EN]};
    end
    if (wr_pend_ff && wr_addr_ff == CMTG_OFS_FREQ) begin
      nxt_freq = hwdata;
    end
    nxt_rdata = rdata_ff;
    if (accept && !hwrite) begin
      // next values so a write just before is seen
      if (!addr_hi_ok) begin
        nxt_rdata = 32'h0;
      end else begin
        case (acc_addr)
          CMTG_OFS_CTRL: nxt_rdata = nxt_ctrl;
          CMTG_OFS_FREQ: nxt_rdata = nxt_freq;
          CMTG_OFS_STAT: nxt_rdata = stat_word;
          CMTG_OFS_CPMF: nxt_rdata = cpmf_ff;
          CMTG_OFS_BUSF: nxt_rdata = busf_ff;
          CMTG_OFS_CORF: nxt_rdata = corf_ff;
          default: nxt_rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0;
      ctrl_ff <= CMTG_CTRL_RST;
      freq_ff <= CMTG_FREQ_RST;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      freq_ff <= nxt_freq;
    end
  end

  // no ticks unless the control enable bit (set by reset) and a supported mode allow
  assign tick_en = ctrl_ff[CMTG_CTRL_TICK_EN] && ratio_ff.valid;

  cmtg_tick_gen cmtg_tick_gen_i (
    .ref_clk (ref_clk),
    .rstn (rstn),
    .enable (tick_en),
    .spacing (spacing_ff),
    .tick (tick_out),
    .in_clk_level (bus_input_clock)
  );

  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = CMTG_HRESP_OKAY;
  assign ratio_out = ratio_ff;
  assign cpm_mult_doubled = halve_ff;
  assign mode_reserved = reserved_ff;

endmodule // cmtg_top
`default_nettype wire

// File: cmtg_strap_src.sv
// board strap and input clock setting model
`timescale 1ns/1ns
`default_nettype none
module cmtg_strap_src
  import cmtg_pkg::*;
(
  // chosen board setting
  input wire logic [CMTG_MODE_W-1:0] code,
  input wire logic halve,
  // strap pins
  output logic [CMTG_HI_W-1:0] hi_pin,
  output logic [CMTG_LO_W-1:0] lo_pin,
  output logic halve_pin
);
  assign hi_pin = code[6:3];
  assign lo_pin = code[2:0];
  assign halve_pin = halve;
endmodule // cmtg_strap_src
`default_nettype wire

// File: cmtg_top_chk_sva.sv
// assertions on decoded ratios and tick timing
`timescale 1ns/1ns
`default_nettype none
module cmtg_top_chk
  import cmtg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // watched outputs
  input wire cmtg_ratio_s ratio_out,
  input wire logic mode_reserved,
  input wire cmtg_tick_s tick_out,
  input wire logic bus_input_clock
);
  logic bic_ff;
  logic rise_ff;
  logic nxt_rise;
  logic ten;
  logic frt;
  logic seen_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // core ratios 2.5 and 3.5 move the second tick
  assign ten = ratio_out.core_x2 == CMTG_CORE_X2_2P5;
  assign frt = ratio_out.core_x2 == CMTG_CORE_X2_3P5;
  // one cycle of slack: tick and level come from separate flops
  always_comb begin
    nxt_rise = bus_input_clock && !bic_ff;
  end
  always_ff @(posedge ref_clk) begin
    bic_ff <= bus_input_clock;
    rise_ff <= nxt_rise;
    // spacing checks start at the first tick after reset
    seen_ff <= rstn && (seen_ff || tick_out.first);
  end
  AST_T1_RISE: assert property (tick_out.first |-> nxt_rise || rise_ff)
    else $error("first tick away from input clock rise");
  AST_T3_HALF: assert property (
    seen_ff && tick_out.third |-> $past(tick_out.first, 70))
    else $error("third tick not half a cycle after first");
  AST_T4_HALF: assert property (
    seen_ff && tick_out.fourth |-> $past(tick_out.second, 70))
    else $error("fourth tick not half a cycle after second");
  AST_SP_QTR: assert property (
    seen_ff && tick_out.second && !ten && !frt |-> $past(tick_out.first, 35))
    else $error("quarter spaced second tick misplaced");
  AST_SP_TEN: assert property (
    seen_ff && tick_out.second && ten |-> $past(tick_out.first, 42))
    else $error("tenths spaced second tick misplaced");
  AST_SP_FRT: assert property (
    seen_ff && tick_out.second && frt |-> $past(tick_out.first, 40))
    else $error("fourteenths spaced second tick misplaced");
  AST_BIC_HALF: assert property (
    $rose(bus_input_clock) |-> ##70 $fell(bus_input_clock))
    else $error("input clock high phase not half a cycle");
  AST_RES_QUIET: assert property (
    mode_reserved && $past(mode_reserved) |-> tick_out == '0)
    else $error("tick in reserved mode");
  AST_HOLD: assert property (
    ratio_out.valid && $past(ratio_out.valid) |-> $stable(ratio_out))
    else $error("ratios changed after capture");
  AST_DIV4: assert property (
    ratio_out.valid && ratio_out.div_x2 == 4'h8 |-> ratio_out.cpm_mult == 4'h2)
    else $error("divider four with wrong multiplier");
  CV_TEN: cover property (tick_out.second && ten);
  CV_FRT: cover property (tick_out.second && frt);
  CV_RES: cover property (mode_reserved);
endmodule // cmtg_top_chk
bind cmtg_top cmtg_top_chk cmtg_top_chk_i (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .ratio_out(ratio_out),
  .mode_reserved(mode_reserved),
  .tick_out(tick_out),
  .bus_input_clock(bus_input_clock)
);
`default_nettype wire

// File: cmtg_top_tb.sv
// self-checking bench for the clock mode and tick generator
`timescale 1ns/1ns
`default_nettype none
module cmtg_top_tb
  import cmtg_pkg::*;
;
  logic ref_clk, rstn, hsel, hwrite, halve;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] code;
  logic [3:0] hi_s;
  logic [2:0] lo_s;
  logic hs_s, hreadyout, hresp, dbl, mres, bic;
  cmtg_ratio_s ratio;
  cmtg_tick_s tick;
  int miscompares = 0;
  int cmp_count = 0;
  cmtg_strap_src cmtg_strap_src_i (.code(code), .halve(halve),
    .hi_pin(hi_s), .lo_pin(lo_s), .halve_pin(hs_s));
  cmtg_top cmtg_top_i (.ref_clk(ref_clk), .rstn(rstn),
    .mode_strap_high_field(hi_s), .mode_strap_low_field(lo_s),
    .pci_clock_halving_select(hs_s), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ratio_out(ratio), .cpm_mult_doubled(dbl),
    .mode_reserved(mres), .tick_out(tick), .bus_input_clock(bic));
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // single word transfer, waits for ready in both phases
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= CMTG_HTRANS_NONSEQ;
    hsel <= 1'b1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", CMTG_HRESP_OKAY, hresp);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic no_ticks();
    logic [3:0] s;
    s = 4'h0;
    // a tick launched as the disabling write lands may still stand
    @(posedge ref_clk);
    repeat (150) begin
      @(posedge ref_clk);
      s = s | tick;
    end
    chk("ticks", 0, 32'(s));
  endtask
  task automatic run_mode(input logic [6:0] c, input logic h,
    input logic [3:0] m, input logic [4:0] k, input logic [3:0] d);
    logic [31:0] f, b;
    int p2, p3, p4, e2, pf;
    code <= c;
    halve <= h;
    do_reset();
    chk("ratio", {18'h0, 1'b1, m, k, d}, 32'(ratio));
    chk("doubled", h, dbl);
    bus(0, CMTG_OFS_STAT, 0, q);
    chk("stat", {4'h0, d, 3'h0, k, m, 3'h0, 1'b1, h, c}, q);
    f = CMTG_FREQ_RST * m * (h ? 32'd2 : 32'd1);
    b = f * 2 / d;
    bus(0, CMTG_OFS_CPMF, 0, q);
    chk("cpmf", f, q);
    bus(0, CMTG_OFS_BUSF, 0, q);
    chk("busf", b, q);
    bus(0, CMTG_OFS_CORF, 0, q);
    chk("corf", b * k / 2, q);
    @(posedge ref_clk iff tick.first);
    for (int i = 1; i < 140; i++) begin
      @(posedge ref_clk);
      if (tick.second) p2 = i;
      if (tick.third) p3 = i;
      if (tick.fourth) p4 = i;
      if (!bic && pf == 0) pf = i;
    end
    e2 = (k == 5'h05) ? 42 : (k == 5'h07) ? 40 : 35;
    chk("tick2", e2, p2);
    chk("tick3", 70, p3);
    chk("tick4", e2 + 70, p4);
    chk("input clock fall", 70, pf);
    $display("mode %h done", c);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard well beyond the expected run
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    code = 7'h04;
    halve = 1'b0;
    run_mode(7'h04, 0, 4'h3, 5'h06, 4'h5);
    run_mode(7'h05, 0, 4'h3, 5'h07, 4'h5);
    run_mode(7'h06, 0, 4'h4, 5'h07, 4'h6);
    run_mode(7'h07, 0, 4'h4, 5'h06, 4'h5);
    for (int l = 1; l < 5; l++) begin
      run_mode({4'h1, 3'(l)}, 0, 4'h2, 5'(8 + 2 * l), 4'h8);
      run_mode({4'h2, 3'(l)}, 0, 4'h3, 5'(5 + l), 4'h5);
    end
    for (int l = 0; l < 5; l++) begin
      run_mode({4'h3, 3'(l)}, 0, 4'h2, 5'(5 + l), 4'h6);
      if (l < 3) run_mode({4'h4, 3'(l)}, 0, 4'h3, 5'(5 + l), 4'h6);
    end
    run_mode(7'h06, 1, 4'h4, 5'h07, 4'h6);
    code <= 7'h00;
    repeat (10) @(posedge ref_clk);
    chk("hold", {18'h0, 1'b1, 4'h4, 5'h07, 4'h6}, 32'(ratio));
    bus(1, CMTG_OFS_FREQ, 32'd50000, q);
    // derived frequencies follow one edge after the write
    @(posedge ref_clk);
    bus(0, CMTG_OFS_CPMF, 0, q);
    chk("cpmf new", 32'd400000, q);
    bus(0, 8'h18, 0, q);
    chk("unmapped", 0, q);
    bus(1, CMTG_OFS_CTRL, 0, q);
    no_ticks();
    $display("register test done");
    halve <= 1'b0;
    do_reset();
    chk("reserved", 1, mres);
    chk("rratio", 0, 32'(ratio));
    bus(0, CMTG_OFS_CTRL, 0, q);
    chk("ctrl", CMTG_CTRL_RST, q);
    bus(0, CMTG_OFS_FREQ, 0, q);
    chk("freq", CMTG_FREQ_RST, q);
    bus(0, CMTG_OFS_CPMF, 0, q);
    chk("rcpmf", 0, q);
    no_ticks();
    $display("reserved test done");
    report_and_stop();
  end
endmodule // cmtg_top_tb
`default_nettype wire
